/* src/pif_pkg.sv */
// Package: register map, field layout and reset values of the peripheral flag block
package pif_pkg;

  // Register data and address widths
  localparam int unsigned DATA_W = 8;
  localparam int unsigned ADDR_W = 4;

  // Register offsets on the plain register port
  localparam logic [ADDR_W-1:0] OFF_FLAGS = 4'h0;    // Pending flags, read/write
  localparam logic [ADDR_W-1:0] OFF_ENABLE = 4'h1;   // Per-source interrupt enable
  localparam logic [ADDR_W-1:0] OFF_CONTROL = 4'h2;  // Global enable
  localparam logic [ADDR_W-1:0] OFF_WAKE_EN = 4'h3;  // Per-source wake enable
  localparam logic [ADDR_W-1:0] OFF_CLEAR = 4'h4;    // Write one to clear a flag
  localparam logic [ADDR_W-1:0] OFF_STATUS = 4'h5;   // Live block state, read only

  // Flag bit positions
  localparam int unsigned BIT_SCANNER = 7;
  localparam int unsigned BIT_CHECKSUM = 6;
  localparam int unsigned BIT_MT2_PULSE_WIDTH = 5;
  localparam int unsigned BIT_MT2_PERIOD = 4;
  localparam int unsigned BIT_MT2_MATCH = 3;
  localparam int unsigned BIT_MT1_PULSE_WIDTH = 2;
  localparam int unsigned BIT_MT1_PERIOD = 1;
  localparam int unsigned BIT_MT1_MATCH = 0;

  // Control and status bit positions
  localparam int unsigned BIT_GLOBAL_ENABLE = 0;
  localparam int unsigned BIT_STAT_IRQ = 0;
  localparam int unsigned BIT_STAT_DIVERT = 1;
  localparam int unsigned BIT_STAT_WAKE = 2;
  localparam int unsigned BIT_STAT_SLEEPING = 3;

  // Reset values
  localparam logic [DATA_W-1:0] RST_FLAGS = 8'h00;
  localparam logic [DATA_W-1:0] RST_ENABLE = 8'h00;
  localparam logic [DATA_W-1:0] RST_CONTROL = 8'h00;
  localparam logic [DATA_W-1:0] RST_WAKE_EN = 8'h00;
  localparam logic [DATA_W-1:0] RST_RDATA = 8'h00;

  // One event pulse per source, packed in flag bit order, high bit first
  typedef struct packed {
    logic scanner_event_flag;
    logic checksum_engine_event_flag;
    logic meas_timer2_pulse_width_flag;
    logic meas_timer2_period_flag;
    logic meas_timer2_match_flag;
    logic meas_timer1_pulse_width_flag;
    logic meas_timer1_period_flag;
    logic meas_timer1_match_flag;
  } pif_events_s;

  // Register port request
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic wr;
    logic rd;
  } pif_bus_req_s;

endpackage : pif_pkg

/* src/pif_top.sv */
// Peripheral interrupt flag register with enable, wake and divert logic
//
// Contract
// - Pending enabled event with global enable diverts the core to interrupt handling.
// - No source encoding; firmware reads the pending flags to find the source.
// - Per-source wake enable lets a pending event wake the sleeping core.
// - Timer 2 pulse width, period, match flags in bits 5, 4, 3.
// - Timer 1 pulse width, period, match flags in bits 2, 1, 0.
// - A flag reads one while pending, zero while not pending.
//
// Register map, eight bits each, all zero after reset except the live core asleep status bit
//   0x0 pending flags, read and plain write
//   0x1 interrupt enable mask, flag layout
//   0x2 control, bit 0 global enable, other bits read zero
//   0x3 wake enable mask, flag layout
//   0x4 write one to clear flags, reads back the flags
//   0x5 live status, read only: irq, divert, wake, core asleep
//   Unmapped offsets read zero, writes ignored
//
// An event landing with a write or clear keeps its flag set,
// so no event is lost while firmware clears older ones.
// Clock enable low freezes every register and output.
//
// Decided for this implementation: the plain strobed port and the register offsets.
module pif_top (
  input wire logic clock,                          // System clock, 10 MHz
  input wire logic rst,                            // Asynchronous reset, active high
  input wire logic ce,                             // Clock enable, freezes state when low
  input wire pif_pkg::pif_bus_req_s bus_req,       // Register port request
  input wire pif_pkg::pif_events_s events,         // Peripheral event pulses
  input wire logic core_sleeping,                  // Core is in low-power state
  output logic [pif_pkg::DATA_W-1:0] rdata,        // Read data, cycle after read strobe
  output logic irq,                                // Any enabled flag pending, level
  output logic core_divert,                        // Interrupt request to the core
  output logic core_wake                           // Wake request to the sleeping core
);

  logic [pif_pkg::DATA_W-1:0] flags_reg;
  logic [pif_pkg::DATA_W-1:0] flags_next;
  logic [pif_pkg::DATA_W-1:0] enable_reg;
  logic [pif_pkg::DATA_W-1:0] control_reg;
  logic [pif_pkg::DATA_W-1:0] wake_en_reg;
  logic [pif_pkg::DATA_W-1:0] rdata_reg;
  logic [pif_pkg::DATA_W-1:0] rdata_next;
  logic [pif_pkg::DATA_W-1:0] event_vec;
  logic [pif_pkg::DATA_W-1:0] status_vec;
  logic irq_reg;
  logic divert_reg;
  logic wake_reg;
  logic irq_next;
  logic divert_next;
  logic wake_next;

  // Only the global enable bit of the control register is writable
  localparam logic [pif_pkg::DATA_W-1:0] CONTROL_MASK = 8'h01 << pif_pkg::BIT_GLOBAL_ENABLE;

  // True when any flag is pending with its gate bit set
  function automatic logic any_gated(
    input logic [pif_pkg::DATA_W-1:0] pend,
    input logic [pif_pkg::DATA_W-1:0] gate
  );
    any_gated = |(pend & gate);
  endfunction : any_gated

  // True when a strobe targets the given offset
  function automatic logic hit(
    input logic strobe,
    input logic [pif_pkg::ADDR_W-1:0] addr,
    input logic [pif_pkg::ADDR_W-1:0] off
  );
    hit = strobe && (addr == off);
  endfunction : hit

  // Event vector in flag bit order
  // scanner, checksum and timer bits
  always_comb begin
    event_vec = '0;
    event_vec[pif_pkg::BIT_SCANNER] = events.scanner_event_flag;
    event_vec[pif_pkg::BIT_CHECKSUM] = events.checksum_engine_event_flag;
    event_vec[pif_pkg::BIT_MT2_PULSE_WIDTH] = events.meas_timer2_pulse_width_flag;
    event_vec[pif_pkg::BIT_MT2_PERIOD] = events.meas_timer2_period_flag;
    event_vec[pif_pkg::BIT_MT2_MATCH] = events.meas_timer2_match_flag;
    event_vec[pif_pkg::BIT_MT1_PULSE_WIDTH] = events.meas_timer1_pulse_width_flag;
    event_vec[pif_pkg::BIT_MT1_PERIOD] = events.meas_timer1_period_flag;
    event_vec[pif_pkg::BIT_MT1_MATCH] = events.meas_timer1_match_flag;
  end

  // Next flag value: software write or clear, then events win
  always_comb begin
    flags_next = flags_reg;
    if (hit(bus_req.wr, bus_req.addr, pif_pkg::OFF_FLAGS)) begin
      flags_next = bus_req.wdata;
    end else if (hit(bus_req.wr, bus_req.addr, pif_pkg::OFF_CLEAR)) begin
      flags_next = flags_reg & ~bus_req.wdata;
    end
    // events set flags regardless of enables
    flags_next = flags_next | event_vec;
  end

  // Pending flag storage
  // a set bit means pending
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      flags_reg <= pif_pkg::RST_FLAGS;
    end else if (ce) begin
      flags_reg <= flags_next;
    end
  end

  // Per-source interrupt enable mask
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      enable_reg <= pif_pkg::RST_ENABLE;
    end else if (ce && hit(bus_req.wr, bus_req.addr, pif_pkg::OFF_ENABLE)) begin
      enable_reg <= bus_req.wdata;
    end
  end

  // Global enable, other control bits stay zero
  // global enable storage
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      control_reg <= pif_pkg::RST_CONTROL;
    end else if (ce && hit(bus_req.wr, bus_req.addr, pif_pkg::OFF_CONTROL)) begin
      control_reg <= bus_req.wdata & CONTROL_MASK;
    end
  end

  // Per-source wake enable mask
  // wake source selection
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      wake_en_reg <= pif_pkg::RST_WAKE_EN;
    end else if (ce && hit(bus_req.wr, bus_req.addr, pif_pkg::OFF_WAKE_EN)) begin
      wake_en_reg <= bus_req.wdata;
    end
  end

  // Request terms from the current flags and gates
  always_comb begin
    irq_next = any_gated(flags_reg, enable_reg);
    divert_next = irq_next && control_reg[pif_pkg::BIT_GLOBAL_ENABLE];
    // wake from wake-enabled flags while asleep
    wake_next = core_sleeping && any_gated(flags_reg, wake_en_reg);
  end

  // Level interrupt output
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      irq_reg <= 1'b0;
    end else if (ce) begin
      irq_reg <= irq_next;
    end
  end

  // Divert request to the core
  // registered divert
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      divert_reg <= 1'b0;
    end else if (ce) begin
      divert_reg <= divert_next;
    end
  end

  // Wake request to the sleeping core
  // registered wake
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      wake_reg <= 1'b0;
    end else if (ce) begin
      wake_reg <= wake_next;
    end
  end

  // Live state seen by software
  always_comb begin
    status_vec = '0;
    status_vec[pif_pkg::BIT_STAT_IRQ] = irq_reg;
    status_vec[pif_pkg::BIT_STAT_DIVERT] = divert_reg;
    status_vec[pif_pkg::BIT_STAT_WAKE] = wake_reg;
    status_vec[pif_pkg::BIT_STAT_SLEEPING] = core_sleeping;
  end

  // Read multiplexer, unmapped offsets read zero
  always_comb begin
    rdata_next = pif_pkg::RST_RDATA;
    if (bus_req.rd) begin
      case (bus_req.addr)
        // source found only by reading flags
        pif_pkg::OFF_FLAGS: rdata_next = flags_reg;
        pif_pkg::OFF_ENABLE: rdata_next = enable_reg;
        pif_pkg::OFF_CONTROL: rdata_next = control_reg;
        pif_pkg::OFF_WAKE_EN: rdata_next = wake_en_reg;
        pif_pkg::OFF_CLEAR: rdata_next = flags_reg;
        pif_pkg::OFF_STATUS: rdata_next = status_vec;
        default: rdata_next = pif_pkg::RST_RDATA;
      endcase
    end
  end

  // Read data stands one cycle only
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      rdata_reg <= pif_pkg::RST_RDATA;
    end else if (ce) begin
      rdata_reg <= rdata_next;
    end
  end

  assign rdata = rdata_reg;
  assign irq = irq_reg;
  assign core_divert = divert_reg;
  assign core_wake = wake_reg;

endmodule : pif_top

/* test/pif_sva.sv */
// Port assertions for the flag block
module pif_chk (
  input wire logic clock, // Clock
  input wire logic rst, // Reset
  input wire logic ce, // Enable
  input wire pif_pkg::pif_bus_req_s bus_req, // Bus
  input wire pif_pkg::pif_events_s events, // Events
  input wire logic core_sleeping, // Asleep
  input wire logic [pif_pkg::DATA_W-1:0] rdata, // Read data
  input wire logic irq, // Interrupt
  input wire logic core_divert, // Divert
  input wire logic core_wake // Wake
);
  logic rf;
  logic wq;
  // Flag read and quiet write decodes
  assign rf = ce && bus_req.rd && bus_req.addr == pif_pkg::OFF_FLAGS;
  assign wq = ce && bus_req.wr && events == 8'h00;
  default clocking @(posedge clock);
  endclocking
  default disable iff (rst);
  property p_rst0;
    $fell(rst) |-> !irq && !core_divert && !core_wake && rdata == 8'h00;
  endproperty
  a_rst0: assert property (p_rst0) else $error("output set after reset");
  property p_idle;
    ce && !bus_req.rd |=> rdata == 8'h00;
  endproperty
  a_idle: assert property (p_idle) else $error("stray read data");
  property p_div;
    core_divert |-> irq;
  endproperty
  a_div: assert property (p_div) else $error("divert without irq");
  property p_wk;
    $rose(core_wake) |-> $past(core_sleeping);
  endproperty
  a_wk: assert property (p_wk) else $error("wake while awake");
  property p_nowk;
    ce && !core_sleeping |=> !core_wake;
  endproperty
  a_nowk: assert property (p_nowk) else $error("wake held");
  property p_set;
    ce && events != 8'h00 ##1 rf |=> (rdata & $past(events, 2)) == $past(events, 2);
  endproperty
  a_set: assert property (p_set) else $error("event flag missing");
  property p_wb;
    wq && bus_req.addr == pif_pkg::OFF_FLAGS ##1 events == 8'h00 ##1 rf && events == 8'h00
      |=> rdata == $past(bus_req.wdata, 3);
  endproperty
  a_wb: assert property (p_wb) else $error("flag write lost");
  property p_clr;
    wq && bus_req.addr == pif_pkg::OFF_CLEAR && bus_req.wdata == 8'hff ##1 ce
      |=> !irq && !core_divert && !core_wake;
  endproperty
  a_clr: assert property (p_clr) else $error("request after clear");
endmodule : pif_chk

bind pif_top pif_chk pif_chk_i (.clock, .rst, .ce, .bus_req, .events, .core_sleeping,
  .rdata, .irq, .core_divert, .core_wake);

/* test/pif_src.sv */
// Event sources and core beside the flag block
module pif_src (
  input wire logic clock, // Clock
  input wire logic [7:0] fire, // Events to raise
  input wire logic nap, // Core goes to sleep
  input wire logic core_wake, // Wake request
  output pif_pkg::pif_events_s events, // Event pulses
  output logic core_sleeping // Core asleep
);
  initial events = '0;
  initial core_sleeping = 1'b0;
  // Event pulses; core sleeps until woken
  always @(posedge clock) begin
    events <= fire;
    if (nap) begin
      core_sleeping <= 1'b1;
    end else if (core_wake) begin
      core_sleeping <= 1'b0;
    end
  end
endmodule : pif_src

/* test/test_peripheral_interrupt_flags.sv */
// Bench for the peripheral flag block
module test_peripheral_interrupt_flags;
  timeunit 1ns;
  timeprecision 1ns;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic nap = 1'b0;
  logic ce = 1'b1;
  logic [7:0] fire = 8'h00;
  pif_pkg::pif_bus_req_s bus_req = '0;
  pif_pkg::pif_events_s events;
  logic core_sleeping, irq, core_divert, core_wake;
  logic [7:0] rdata;
  int bad_count = 0;
  int cmp_count = 0;
  always #50 clock = ~clock;
  pif_top pif_top_i (.clock, .rst, .ce, .bus_req, .events, .core_sleeping, .rdata,
    .irq, .core_divert, .core_wake);
  pif_src pif_src_i (.clock, .fire, .nap, .core_wake, .events, .core_sleeping);
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    bus_req <= '{a, d, 1'b1, 1'b0};
    @(posedge clock);
    bus_req <= '0;
    @(posedge clock);
  endtask : wr
  task automatic rd(input logic [3:0] a, input logic [7:0] exp);
    bus_req <= '{a, 8'h00, 1'b0, 1'b1};
    @(posedge clock);
    bus_req <= '0;
    #1 check(rdata, exp);
    @(posedge clock);
  endtask : rd
  task automatic outs(input logic [2:0] exp);
    @(posedge clock);
    #1 check({5'h00, core_wake, core_divert, irq}, {5'h00, exp});
    @(posedge clock);
  endtask : outs
  task automatic pulse(input logic [7:0] f);
    fire <= f;
    @(posedge clock);
    fire <= 8'h00;
    @(posedge clock);
  endtask : pulse
  task automatic t_basic();
    for (int a = 0; a < 4; a++) rd(4'(a), 8'h00);
    wr(pif_pkg::OFF_FLAGS, 8'ha5);
    rd(pif_pkg::OFF_FLAGS, 8'ha5);
    wr(pif_pkg::OFF_CLEAR, 8'h81);
    rd(pif_pkg::OFF_FLAGS, 8'h24);
    rd(4'hf, 8'h00);
    wr(pif_pkg::OFF_ENABLE, 8'h5a);
    rd(pif_pkg::OFF_ENABLE, 8'h5a);
    wr(pif_pkg::OFF_CONTROL, 8'hff);
    rd(pif_pkg::OFF_CONTROL, 8'h01);
    wr(pif_pkg::OFF_WAKE_EN, 8'hc3);
    rd(pif_pkg::OFF_WAKE_EN, 8'hc3);
    rd(pif_pkg::OFF_CLEAR, 8'h24);
    wr(pif_pkg::OFF_CLEAR, 8'hff);
    wr(pif_pkg::OFF_ENABLE, 8'h00);
    wr(pif_pkg::OFF_CONTROL, 8'h00);
    wr(pif_pkg::OFF_WAKE_EN, 8'h00);
    $display("register test done");
  endtask : t_basic
  task automatic t_bits();
    for (int i = 0; i < 8; i++) begin
      pulse(8'h01 << i);
      rd(pif_pkg::OFF_FLAGS, 8'h01 << i);
      wr(pif_pkg::OFF_CLEAR, 8'hff);
    end
    $display("flag position test done");
  endtask : t_bits
  task automatic t_race();
    fire <= 8'h02;
    @(posedge clock);
    fire <= 8'h00;
    bus_req <= '{pif_pkg::OFF_CLEAR, 8'hff, 1'b1, 1'b0};
    @(posedge clock);
    bus_req <= '0;
    @(posedge clock);
    rd(pif_pkg::OFF_FLAGS, 8'h02);
    wr(pif_pkg::OFF_CLEAR, 8'hff);
    $display("set over clear test done");
  endtask : t_race
  task automatic t_freeze();
    ce <= 1'b0;
    pulse(8'h08);
    wr(pif_pkg::OFF_FLAGS, 8'hff);
    ce <= 1'b1;
    rd(pif_pkg::OFF_FLAGS, 8'h00);
    $display("clock enable test done");
  endtask : t_freeze
  task automatic t_irq();
    wr(pif_pkg::OFF_CLEAR, 8'hff);
    wr(pif_pkg::OFF_ENABLE, 8'h01);
    wr(pif_pkg::OFF_CONTROL, 8'h01);
    pulse(8'h01);
    outs(3'h3);
    rd(pif_pkg::OFF_STATUS, 8'h03);
    wr(pif_pkg::OFF_ENABLE, 8'h00);
    outs(3'h0);
    wr(pif_pkg::OFF_ENABLE, 8'h01);
    wr(pif_pkg::OFF_CONTROL, 8'h00);
    outs(3'h1);
    rd(pif_pkg::OFF_FLAGS, 8'h01);
    wr(pif_pkg::OFF_CLEAR, 8'h01);
    outs(3'h0);
    $display("interrupt test done");
  endtask : t_irq
  task automatic t_wake();
    wr(pif_pkg::OFF_WAKE_EN, 8'h80);
    nap <= 1'b1;
    @(posedge clock);
    nap <= 1'b0;
    rd(pif_pkg::OFF_STATUS, 8'h08);
    pulse(8'h80);
    outs(3'h4);
    rd(pif_pkg::OFF_STATUS, 8'h04);
    outs(3'h0);
    $display("wake test done");
  endtask : t_wake
  task automatic t_reset();
    wr(pif_pkg::OFF_FLAGS, 8'hff);
    wr(pif_pkg::OFF_ENABLE, 8'hff);
    outs(3'h1);
    rst <= 1'b1;
    repeat (2) @(posedge clock);
    rst <= 1'b0;
    @(posedge clock);
    rd(pif_pkg::OFF_FLAGS, 8'h00);
    rd(pif_pkg::OFF_ENABLE, 8'h00);
    outs(3'h0);
    $display("reset test done");
  endtask : t_reset
  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : finish_test
  // Main sequence after reset
  initial begin
    repeat (10) @(posedge clock);
    rst <= 1'b0;
    @(posedge clock);
    t_basic();
    t_bits();
    t_race();
    t_freeze();
    t_irq();
    t_wake();
    t_reset();
    finish_test();
  end
  // Hang limit
  initial begin
    #2ms;
    bad_count++;
    finish_test();
  end
endmodule : test_peripheral_interrupt_flags
